// *** core/pcd_divider_ctl.sv ***
`timescale 1ns/1ps
module pcd_divider_ctl #(
    parameter int SCK_HALF = pcd_pkg::SCK_HALF_CYC
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic [1:0] hresp,
    pcd_link_if.ctl link
);
    logic [31:0] ctrl_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic [1:0] sdo_sync_q;
    logic rst_q;
    logic [7:0] rst_cnt_q;
    logic [7:0] tx_q;
    logic [2:0] bit_q;
    logic [7:0] hc_q;
    logic sck_q;
    logic sdi_q;
    logic ldn_q;
    logic start;
    logic half_done;
    pcd_pkg::pcd_ser_t ss_q;

    // Writes complete with no wait state, reads take one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout_q <= 1'b1;
            if (hsel && hready && htrans == pcd_pkg::HTRANS_NONSEQ)
            begin
                wr_q <= hwrite;
                rd_q <= ~hwrite;
                addr_q <= haddr[7:0];
                hreadyout_q <= hwrite;
            end
            if (rd_q)
            begin
                case (addr_q)
                    pcd_pkg::ADDR_CTRL: hrdata_q <= ctrl_q;
                    pcd_pkg::ADDR_SER_TX: hrdata_q <= {24'h00_0000, tx_q};
                    pcd_pkg::ADDR_STATUS:
                        hrdata_q <= {29'h0000_0000, sdo_sync_q[1], rst_q, ss_q != pcd_pkg::SS_IDLE};
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = pcd_pkg::HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_q <= pcd_pkg::CTRL_RESET;
        else if (ce && wr_q && addr_q == pcd_pkg::ADDR_CTRL)
            ctrl_q <= {16'h0000, hwdata[15:8], 6'h00, hwdata[1:0]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sdo_sync_q <= 2'h0;
        else if (ce)
            sdo_sync_q <= {sdo_sync_q[0], link.serial_data_out};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_q <= 1'b0;
            rst_cnt_q <= 8'h00;
        end
        else if (ce)
        begin
            if (ctrl_q[pcd_pkg::CTRL_RST])
                rst_q <= 1'b1;
            else if (rst_cnt_q >= 8'(pcd_pkg::RST_HOLD_CYC))
                rst_q <= 1'b0;
            if (!rst_q)
                rst_cnt_q <= 8'h00;
            else if (rst_cnt_q != 8'hFF)
                rst_cnt_q <= rst_cnt_q + 8'h01;
        end
    end

    // A byte written while a transfer runs is dropped
    assign start = wr_q && addr_q == pcd_pkg::ADDR_SER_TX && ss_q == pcd_pkg::SS_IDLE;
    assign half_done = hc_q == 8'(SCK_HALF - 1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ss_q <= pcd_pkg::SS_IDLE;
            tx_q <= 8'h00;
            bit_q <= 3'h0;
            hc_q <= 8'h00;
            sck_q <= 1'b0;
            sdi_q <= 1'b0;
            ldn_q <= 1'b1;
        end
        else if (ce)
        begin
            hc_q <= half_done ? 8'h00 : hc_q + 8'h01;
            case (ss_q)
                pcd_pkg::SS_IDLE:
                begin
                    hc_q <= 8'h00;
                    if (start)
                    begin
                        tx_q <= hwdata[7:0];
                        sdi_q <= hwdata[7];
                        bit_q <= 3'h0;
                        ldn_q <= 1'b0;
                        ss_q <= pcd_pkg::SS_LOW;
                    end
                end
                pcd_pkg::SS_LOW:
                    if (half_done)
                    begin
                        sck_q <= 1'b1;
                        ss_q <= pcd_pkg::SS_HIGH;
                    end
                pcd_pkg::SS_HIGH:
                    if (half_done)
                    begin
                        sck_q <= 1'b0;
                        bit_q <= bit_q + 3'h1;
                        sdi_q <= tx_q[3'h6 - bit_q];
                        ss_q <= (bit_q == 3'h7) ? pcd_pkg::SS_TAIL : pcd_pkg::SS_LOW;
                    end
                pcd_pkg::SS_TAIL:
                    if (half_done)
                    begin
                        ldn_q <= 1'b1;
                        ss_q <= pcd_pkg::SS_GAP;
                    end
                pcd_pkg::SS_GAP:
                    if (half_done)
                        ss_q <= pcd_pkg::SS_IDLE;
                default:
                    ss_q <= pcd_pkg::SS_IDLE;
            endcase
        end
    end

    assign link.serial_sel = ctrl_q[pcd_pkg::CTRL_SEL];
    assign link.ratio_code_bits = ctrl_q[pcd_pkg::CTRL_CODE +: 8];
    assign link.ext_reset = rst_q;
    assign link.serial_clock_in = sck_q;
    assign link.serial_data_in = sdi_q;
    assign link.serial_load_n = ldn_q;
endmodule // pcd_divider_ctl

// *** core/pcd_divider_dev.sv ***
`timescale 1ns/1ps
module pcd_divider_dev (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    pcd_link_if.dev link,
    output logic clk_div_out,
    output logic div_active
);
    logic [pcd_pkg::SYN_W-1:0] meta_q;
    logic [pcd_pkg::SYN_W-1:0] sync_q;
    logic [pcd_pkg::SYN_W-1:0] prev_q;
    logic [1:0] primed_q;
    logic [7:0] shift_q;
    logic [7:0] ser_ratio_q;
    logic [7:0] ratio_q;
    logic [7:0] cnt_q;
    logic [7:0] div_cnt_q;
    logic [7:0] div_cnt_d;
    logic [8:0] ratio_n;
    logic [8:0] half_hi;
    logic odd_q;
    logic one_q;
    logic div_en_q;
    logic a_q;
    logic b_q;
    logic sdo_q;
    logic sel;
    logic sck_rise;
    logic load_rise;
    logic code_chg;
    logic change;
    logic xrst;
    logic [7:0] target;
    pcd_pkg::pcd_state_t state_q;

    // Every pin passes two flip-flops before use
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_q <= pcd_pkg::SYN_RESET;
            sync_q <= pcd_pkg::SYN_RESET;
            prev_q <= pcd_pkg::SYN_RESET;
        end
        else if (ce)
        begin
            meta_q <= {link.ext_reset, link.serial_sel, link.serial_load_n,
                       link.serial_clock_in, link.serial_data_in, link.ratio_code_bits};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Change detection waits until the pipeline holds real pin values
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            primed_q <= 2'h0;
        else if (ce && primed_q != 2'h3)
            primed_q <= primed_q + 2'h1;
    end

    assign sel = sync_q[pcd_pkg::SYN_SEL];
    assign xrst = sync_q[pcd_pkg::SYN_RST];
    assign sck_rise = sync_q[pcd_pkg::SYN_SCK] & ~prev_q[pcd_pkg::SYN_SCK];
    assign load_rise = sync_q[pcd_pkg::SYN_LDN] & ~prev_q[pcd_pkg::SYN_LDN];
    assign code_chg = sync_q[pcd_pkg::SYN_CODE +: 8] != prev_q[pcd_pkg::SYN_CODE +: 8];
    assign change = (primed_q == 2'h3) & ((sel != prev_q[pcd_pkg::SYN_SEL])
                  | (~sel & code_chg) | (sel & load_rise));
    assign target = sel ? ser_ratio_q : sync_q[pcd_pkg::SYN_CODE +: 8];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            shift_q <= 8'h00;
        else if (ce && sel && sck_rise)
            shift_q <= {shift_q[6:0], sync_q[pcd_pkg::SYN_SDI]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ser_ratio_q <= pcd_pkg::RATIO_RESET;
        else if (ce && sel && load_rise)
            ser_ratio_q <= shift_q;
    end

    // Echo of the byte leaving the shifter, for daisy chaining
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sdo_q <= 1'b0;
        else if (ce)
            sdo_q <= shift_q[7];
    end

    assign link.serial_data_out = sdo_q;

    // sequence timing in input clock periods
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Power-up runs the idle part of the self reset
            state_q <= pcd_pkg::ST_IDLE;
            cnt_q <= 8'h00;
        end
        else if (ce)
        begin
            cnt_q <= cnt_q + 8'h01;
            case (state_q)
                pcd_pkg::ST_XRST:
                begin
                    cnt_q <= 8'h00;
                    if (!xrst)
                        state_q <= pcd_pkg::ST_RWAIT;
                end
                pcd_pkg::ST_WAIT:
                begin
                    if (cnt_q == 8'(pcd_pkg::CHANGE_WAIT_CYC - 1))
                    begin
                        state_q <= pcd_pkg::ST_IDLE;
                        cnt_q <= 8'h00;
                    end
                end
                pcd_pkg::ST_RWAIT:
                begin
                    if (cnt_q == 8'(pcd_pkg::CHANGE_WAIT_CYC - 1))
                        state_q <= pcd_pkg::ST_RUN;
                end
                pcd_pkg::ST_IDLE:
                begin
                    if (cnt_q == 8'(pcd_pkg::RESUME_CYC - 1))
                        state_q <= pcd_pkg::ST_RUN;
                end
                pcd_pkg::ST_RUN:
                    cnt_q <= 8'h00;
                default:
                    state_q <= pcd_pkg::ST_IDLE;
            endcase
            // A new change restarts the whole sequence
            if (change)
            begin
                state_q <= pcd_pkg::ST_WAIT;
                cnt_q <= 8'h00;
            end
            if (xrst)
            begin
                state_q <= pcd_pkg::ST_XRST;
                cnt_q <= 8'h00;
            end
        end
    end

    // Output runs in RUN and keeps its old ratio through WAIT
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_en_q <= 1'b0;
        else if (ce)
        begin
            if (xrst || state_q == pcd_pkg::ST_IDLE || state_q == pcd_pkg::ST_XRST
                || state_q == pcd_pkg::ST_RWAIT)
                div_en_q <= 1'b0;
            else if (state_q == pcd_pkg::ST_RUN)
                div_en_q <= 1'b1;
        end
    end

    // ratio latched only while output is stopped, so a run never mixes ratios
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ratio_q <= pcd_pkg::RATIO_RESET;
            odd_q <= 1'b1;
            one_q <= 1'b1;
        end
        else if (ce && state_q != pcd_pkg::ST_RUN && !div_en_q)
        begin
            ratio_q <= target;
            odd_q <= target[0];
            one_q <= target == 8'h01;
        end
    end

    assign ratio_n = (ratio_q == 8'h00) ? 9'h100 : {1'b0, ratio_q};
    assign half_hi = (ratio_n + 9'h001) >> 1;
    assign div_cnt_d = ({1'b0, div_cnt_q} == ratio_n - 9'h001) ? 8'h00 : div_cnt_q + 8'h01;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt_q <= 8'h00;
            a_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!div_en_q || xrst)
            begin
                div_cnt_q <= 8'h00;
                a_q <= 1'b0;
            end
            else
            begin
                div_cnt_q <= div_cnt_d;
                a_q <= {1'b0, div_cnt_d} < half_hi;
            end
        end
    end

    // half-cycle copy trims odd ratios to an even high time
    always_ff @(negedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            b_q <= 1'b0;
        else if (ce)
            b_q <= a_q;
    end

    // glue of clock flops; ratio one passes the input clock itself
    always_comb
    begin
        if (one_q)
            clk_div_out = a_q & b_q & hclk;
        else if (odd_q)
            clk_div_out = a_q & b_q;
        else
            clk_div_out = a_q;
    end

    assign div_active = div_en_q;
endmodule // pcd_divider_dev

// *** core/pcd_link_if.sv ***
`timescale 1ns/1ps
interface pcd_link_if;
    logic [7:0] ratio_code_bits;
    logic serial_sel;
    logic serial_data_in;
    logic serial_clock_in;
    logic serial_load_n;
    logic ext_reset;
    logic serial_data_out;

    modport dev (
        input ratio_code_bits,
        input serial_sel,
        input serial_data_in,
        input serial_clock_in,
        input serial_load_n,
        input ext_reset,
        output serial_data_out
    );

    modport ctl (
        output ratio_code_bits,
        output serial_sel,
        output serial_data_in,
        output serial_clock_in,
        output serial_load_n,
        output ext_reset,
        input serial_data_out
    );
endinterface // pcd_link_if

// *** core/pcd_pkg.sv ***
// Summary of operation
// - Divide input clock by 1 to 256
// - Output duty cycle always fifty percent
// - Select pin chooses serial or parallel ratio
// - Parallel code is unsigned, bit seven MSB
// - All-zero code divides by 256
// - Idle 64 to 128 cycles plus 1.6ns
// - Resume with new ratio after 192 cycles
// - Serial byte sent MSB first
// - Serial data sampled on serial clock rise
// - Load rising edge makes shifted byte active
// - Master holds load low during transfer
// - Self reset at power-up and control change
// - External reset high forces output low
// - Resume 64 to 128 cycles after release
// - Reset pulse longer than 64 cycles
package pcd_pkg;
    localparam int RATIO_W = 8;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int EXTRA_DELAY_PS = 1600;
    localparam int EXTRA_CYC = (EXTRA_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CHANGE_WAIT_MIN = 64;
    localparam int CHANGE_WAIT_CYC = CHANGE_WAIT_MIN + EXTRA_CYC;
    localparam int RESUME_CYC = 192;
    localparam int RST_MIN_CYC = 64;
    localparam int RST_HOLD_CYC = RST_MIN_CYC + 1;
    localparam int SCK_HALF_CYC = 4;
    // Positions in the device's synchroniser bundle
    localparam int SYN_CODE = 0;
    localparam int SYN_SDI = 8;
    localparam int SYN_SCK = 9;
    localparam int SYN_LDN = 10;
    localparam int SYN_SEL = 11;
    localparam int SYN_RST = 12;
    localparam int SYN_W = 13;
    localparam logic [SYN_W-1:0] SYN_RESET = 13'h0400;
    localparam logic [7:0] RATIO_RESET = 8'h01;
    // Controller register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SER_TX = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_SEL = 0;
    localparam int CTRL_RST = 1;
    localparam int CTRL_CODE = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RST = 1;
    localparam int STAT_SDO = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_RWAIT, ST_RUN, ST_XRST} pcd_state_t;
    typedef enum logic [2:0] {SS_IDLE, SS_LOW, SS_HIGH, SS_TAIL, SS_GAP} pcd_ser_t;
endpackage

// *** verif/pcd_divider_tb.sv ***
`timescale 1ns/1ps
module pcd_divider_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [1:0] hresp;
    logic clk_div_out;
    logic div_active;
    logic [7:0] sent_q = 8'h00;
    logic [7:0] got_q = 8'h00;
    int nbits = 0;
    int error_cnt = 0;
    int n_tests = 0;
    int k;
    logic [7:0] codes [6] = '{8'h02, 8'h03, 8'h07, 8'h00, 8'hFF, 8'h01};
    int ratios [6] = '{2, 3, 7, 256, 255, 1};

    pcd_link_if link_i ();
    pcd_divider_ctl pcd_divider_ctl_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .link(link_i));
    pcd_divider_dev pcd_divider_dev_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .link(link_i), .clk_div_out(clk_div_out), .div_active(div_active));
    pcd_link_asserts pcd_link_asserts_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .htrans(htrans), .hwrite(hwrite), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .ratio_code_bits(link_i.ratio_code_bits),
        .serial_sel(link_i.serial_sel), .serial_data_in(link_i.serial_data_in),
        .serial_clock_in(link_i.serial_clock_in), .serial_load_n(link_i.serial_load_n),
        .ext_reset(link_i.ext_reset), .clk_div_out(clk_div_out), .div_active(div_active));

    always #2 hclk = ~hclk;

    task automatic end_of_test;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic fail(input string m);
        error_cnt++;
        $display("MISMATCH %0t %s", $time, m);
    endtask

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e)
            fail(m);
    endtask

    task automatic cmp_rng(input int g, input int lo, input int hi, input string m);
        n_tests++;
        if (g < lo || g > hi)
            fail(m);
    endtask

    task automatic cmp_t(input realtime g, input realtime e, input string m);
        n_tests++;
        if (g < e - 0.01 || g > e + 0.01)
            fail(m);
    endtask

    // Waits poll once per rising clock edge, so they stay aligned just after a rising edge
    task automatic wait_sig(input bit rst_pin, input logic lvl, input int lim, output int n);
        n = 0;
        while ((rst_pin ? link_i.ext_reset : div_active) !== lvl && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= lim)
        begin
            fail("wait ran out");
            end_of_test;
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pcd_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic wait_rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge hclk);
            i++;
        end
        while (hreadyout !== 1'b1 && i < 50);
        if (i >= 50)
        begin
            fail("bus hang");
            end_of_test;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        cmp32(r, e, "read data");
    endtask

    // Bounded wait for one edge of the divided clock; longest half period is 512 ns
    task automatic wait_out(input bit rise);
        fork
            begin
                if (rise)
                    @(posedge clk_div_out);
                else
                    @(negedge clk_div_out);
            end
            begin
                #1200;
                fail("divided clock stuck");
                end_of_test;
            end
        join_any
        disable fork;
    endtask

    // Second full period is timed; the first may follow the restart
    task automatic measure(input int n);
        realtime t0, t1, t2;
        wait_out(1'b1);
        wait_out(1'b1);
        t0 = $realtime;
        wait_out(1'b0);
        t1 = $realtime;
        wait_out(1'b1);
        t2 = $realtime;
        cmp_t(t1 - t0, n * 2.0, "high time");
        cmp_t(t2 - t0, n * 4.0, "period");
        @(posedge hclk);
    endtask

    task automatic change(input logic [7:0] a, input logic [31:0] d, input int n, input int lo);
        int c;
        wr(a, d);
        wait_sig(1'b0, 1'b0, 1000, c);
        cmp_rng(c, lo, lo + 68, "idle entry");
        wait_sig(1'b0, 1'b1, 1000, c);
        cmp_rng(c, 192, 200, "idle length");
        if (n > 0)
            measure(n);
    endtask

    task automatic hold_active(input int cyc);
        int c;
        c = 0;
        repeat (cyc)
        begin
            @(posedge hclk);
            if (div_active === 1'b1)
                c++;
        end
        cmp_rng(c, cyc, cyc, "output restarted");
    endtask

    // Frame content seen on the wire, MSB first; one process owns the bit count
    always @(posedge link_i.serial_clock_in or posedge link_i.serial_load_n)
        if (link_i.serial_load_n === 1'b0)
        begin
            got_q <= {got_q[6:0], link_i.serial_data_in};
            nbits++;
        end
        else if (hresetn)
        begin
            cmp32({24'h0, got_q}, {24'h0, sent_q}, "frame byte");
            cmp_rng(nbits, 8, 8, "frame length");
            nbits = 0;
        end

    initial
    begin
        #200us;
        fail("run timed out");
        end_of_test;
    end

    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp32({19'h0, link_i.ratio_code_bits, link_i.serial_sel, link_i.serial_clock_in,
            link_i.serial_data_in, link_i.serial_load_n, link_i.ext_reset}, 32'h22, "pins");
        rd(pcd_pkg::ADDR_CTRL, pcd_pkg::CTRL_RESET);
        rd(8'h0C, 32'h0);
        rd(pcd_pkg::ADDR_STATUS, 32'h0);
        wait_sig(1'b0, 1'b1, 1000, k);
        cmp_rng(k, 180, 200, "power-up idle");
        measure(1);
        foreach (codes[i])
            change(pcd_pkg::ADDR_CTRL, {16'h0, codes[i], 8'h00}, ratios[i], 64);
        sent_q = 8'h05;
        wr(pcd_pkg::ADDR_SER_TX, 32'h05);
        hold_active(300);
        change(pcd_pkg::ADDR_CTRL, 32'h0000_0101, 0, 64);
        sent_q = 8'h06;
        change(pcd_pkg::ADDR_SER_TX, 32'h06, 6, 137);
        wr(pcd_pkg::ADDR_CTRL, 32'h0000_0901);
        hold_active(300);
        wr(pcd_pkg::ADDR_CTRL, 32'h0000_0903);
        repeat (8) @(posedge hclk);
        cmp32({30'h0, clk_div_out, div_active}, 32'h0, "held low");
        rd(pcd_pkg::ADDR_STATUS, 32'h2);
        wr(pcd_pkg::ADDR_CTRL, 32'h0000_0901);
        wait_sig(1'b1, 1'b0, 200, k);
        wait_sig(1'b0, 1'b1, 1000, k);
        cmp_rng(k, 64, 80, "resume after reset");
        measure(6);
        // A byte with its top bit set shows up on the echo once the frame is over
        sent_q = 8'h83;
        wr(pcd_pkg::ADDR_SER_TX, 32'h83);
        repeat (80) @(posedge hclk);
        rd(pcd_pkg::ADDR_SER_TX, 32'h83);
        rd(pcd_pkg::ADDR_STATUS, 32'h4);
        end_of_test;
    end
endmodule // pcd_divider_tb

// *** verif/pcd_link_asserts.sv ***
`timescale 1ns/1ps
module pcd_link_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [7:0] ratio_code_bits,
    input wire logic serial_sel,
    input wire logic serial_data_in,
    input wire logic serial_clock_in,
    input wire logic serial_load_n,
    input wire logic ext_reset,
    input wire logic clk_div_out,
    input wire logic div_active
);
    logic [3:0] sck_cnt_q;
    logic sck_prev_q;
    logic [7:0] rst_cnt_q;
    logic [9:0] low_cnt_q;
    logic req;
    assign req = hsel && hready && (htrans == pcd_pkg::HTRANS_NONSEQ);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Reset and idle counters saturate so long spells cannot wrap into a false failure
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sck_cnt_q <= 4'h0;
            sck_prev_q <= 1'b0;
            rst_cnt_q <= 8'h00;
            low_cnt_q <= 10'h000;
        end
        else
        begin
            sck_prev_q <= serial_clock_in;
            if (serial_load_n)
                sck_cnt_q <= 4'h0;
            else if (serial_clock_in && !sck_prev_q)
                sck_cnt_q <= sck_cnt_q + 4'h1;
            if (!ext_reset)
                rst_cnt_q <= 8'h00;
            else if (rst_cnt_q != 8'hFF)
                rst_cnt_q <= rst_cnt_q + 8'h01;
            if (div_active)
                low_cnt_q <= 10'h000;
            else if (low_cnt_q != 10'h3FF)
                low_cnt_q <= low_cnt_q + 10'h001;
        end
    end

    a_frame_eight_bits: assert property ($rose(serial_load_n) |-> sck_cnt_q == 4'h8)
        else $error("frame did not carry eight clock rises");
    a_data_stable_rise: assert property ($rose(serial_clock_in) |-> $stable(serial_data_in))
        else $error("serial data moved at the serial clock rise");
    a_clock_still_idle: assert property (serial_load_n |-> !serial_clock_in)
        else $error("serial clock high outside a frame");
    a_reset_pulse_long: assert property ($fell(ext_reset) |-> rst_cnt_q > 8'h40)
        else $error("reset pulse too short");
    a_reset_output_low: assert property (ext_reset [*6] |-> !div_active && !clk_div_out)
        else $error("output not held low during reset");
    a_idle_static_low: assert property (!div_active && $past(!div_active) |-> !clk_div_out)
        else $error("output toggles while idle");
    a_change_idle_window: assert property ($changed(ratio_code_bits) && !serial_sel
        && div_active |-> ##60 div_active ##[1:72] !div_active)
        else $error("idle entry outside its window");
    a_resume_gap: assert property ($rose(div_active) |-> low_cnt_q >= 10'h040)
        else $error("output resumed too early");
    a_read_one_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (req && hwrite |=> hreadyout)
        else $error("write was stalled");
    a_resp_okay: assert property (hsel |-> hresp == pcd_pkg::HRESP_OKAY)
        else $error("response not okay");

    c_frame: cover property ($rose(serial_load_n));
    c_ext_reset: cover property ($fell(ext_reset));
    c_resume: cover property ($rose(div_active) && serial_sel);
endmodule // pcd_link_asserts
